// file: design/reset_cause_pkg.sv
// Constants shared by the reset-cause block: register map, field positions, reset values.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package reset_cause_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_RESET_CTRL  = 8'h00;
   localparam logic [7:0] OFF_STACK_PTR   = 8'h04;
   localparam logic [7:0] OFF_TOS         = 8'h08;
   localparam logic [7:0] OFF_CONFIG      = 8'h0C;
   localparam logic [7:0] OFF_INT_STATUS  = 8'h10;
   localparam logic [7:0] OFF_INT_MASK    = 8'h14;
   localparam logic [7:0] OFF_WAKE_FLAGS  = 8'h18;

   // Reset control register fields (flags read 1 while the cause has not occurred)
   localparam int RC_W    = 6;
   localparam int BIT_CM  = 5;
   localparam int BIT_RI  = 4;
   localparam int BIT_TO  = 3;
   localparam int BIT_PD  = 2;
   localparam int BIT_POR = 1;
   localparam int BIT_BOR = 0;
   localparam logic [5:0] RC_POR_VAL = 6'h3C;

   // Stack pointer register fields
   localparam int BIT_STK_FULL = 7;
   localparam int BIT_STK_UNF  = 6;
   localparam int SP_W         = 5;

   // Configuration register fields and reset values
   localparam int   BIT_STK_RST_EN = 0;
   localparam logic CFG_STK_RST_VAL = 1'b1;

   // Restart addresses
   localparam int RESTART_VEC = 'h0000;
   localparam int HI_INT_VEC  = 'h0008;
   localparam int LO_INT_VEC  = 'h0018;
   localparam int PC_STEP     = 2;

   // Interrupt status bits, one per event class
   localparam int IRQ_BOR      = 0;
   localparam int IRQ_CM       = 1;
   localparam int IRQ_EXTERNAL_RESET_PIN     = 2;
   localparam int IRQ_WDT_RST  = 3;
   localparam int IRQ_WDT_WAKE = 4;
   localparam int IRQ_STK_FULL = 5;
   localparam int IRQ_STK_UNF  = 6;
   localparam int IRQ_INSTR    = 7;
   localparam int IRQ_INT_WAKE = 8;
   localparam int IRQ_W        = 9;

   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      PM_FULL,
      PM_RUN,
      PM_IDLE_SLEEP
   } power_mode_e;

   typedef enum logic [3:0] {
      EV_NONE,
      EV_BOR,
      EV_CM,
      EV_EXTERNAL_RESET_PIN,
      EV_WDT,
      EV_STK_FULL,
      EV_STK_UNF,
      EV_INSTR,
      EV_INT_WAKE
   } event_e;

endpackage

// file: design/pin_sync.sv
// Two-flop synchroniser for asynchronous level inputs, one chain per bit.
// Assumes inputs are slow levels; pulses shorter than two clocks may be lost.
`timescale 1ns/1ps
module pin_sync #(
   parameter int         WIDTH   = 2,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   import reset_cause_pkg::*;

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            meta_q[b] <= RST_VAL[b];
            sync_o[b] <= RST_VAL[b];
         end else if (ce_i) begin
            meta_q[b] <= async_i[b];
            sync_o[b] <= meta_q[b];
         end
      end
   end

endmodule

// file: design/reset_cause_status_logic.sv
// Reset-cause recorder and restart-point selector with a Wishbone register slave.
// Assumes rst_i is the power-on reset; core events are one-cycle pulses on clk_i.
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

// Notes on behaviour
// R1 - Power-on sets mismatch, instr, timeout, powerdown; clears others; restart at zero.
// R2 - Brown-out sets mismatch, instr, timeout, powerdown; clears brownout; others kept.
// R3 - Pin reset in Run sets timeout; in Idle or Sleep also clears powerdown.
// R4 - Pin reset at full power keeps every flag and restarts at zero.
// R5 - Enabled stack overflow resets to zero, sets full flag, keeps others.
// R6 - Underflow sets its flag, with reset if enabled, without reset otherwise.
// R7 - Watchdog in full power or Run resets to zero and clears timeout.
// R8 - Watchdog in Idle or Sleep wakes at pc plus two, clears timeout, powerdown.
// R9 - Interrupt wake clears powerdown; vector if enabled, else pc plus two.
// R10 - Enabled interrupt wake pushes current pc into top of stack.
// R11 - Enabled interrupt wake advances the stack pointer with the push.
// R12 - Interrupt flags that caused a wake stay set, not reset.
// R13 - Unimplemented bits read zero; unknown bits are not forced at reset.
// R14 - Mismatch flag clears on mismatch reset only; power-on and brown-out set it.
// R15 - Power-on flag is set only by software, never by hardware.
// R16 - Reset instruction clears its flag, restarts at zero, keeps other flags.
module reset_cause_status_logic #(
   parameter int   PC_W        = 21,
   parameter int   WAKE_W      = 8,
   parameter logic BOR_PRESENT = 1'b1
) (
   // Clock, reset, enable
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        ce_i,
   // Pins
   input  wire logic                        external_reset_pin_n_i,
   input  wire logic                        brownout_i,
   // Core events and state
   input  wire logic                        cfg_mismatch_i,
   input  wire logic                        watchdog_timer_timeout_i,
   input  wire logic                        stack_overflow_i,
   input  wire logic                        stack_underflow_i,
   input  wire logic                        reset_instr_i,
   input  wire logic                        int_wake_i,
   input  wire logic                        int_high_prio_i,
   input  wire logic                        high_priority_int_enable_i,
   input  wire logic                        low_priority_int_enable_i,
   input  wire reset_cause_pkg::power_mode_e power_mode_i,
   input  wire logic [PC_W-1:0]             pc_i,
   input  wire logic [WAKE_W-1:0]           int_src_flags_i,
   // Restart control
   output logic                             restart_o,
   output logic                             core_reset_o,
   output logic      [PC_W-1:0]             restart_pc_o,
   output logic      [PC_W-1:0]             top_of_stack_o,
   output logic      [reset_cause_pkg::SP_W-1:0] stack_ptr_o,
   output logic      [WAKE_W-1:0]           held_int_flags_o,
   // Wishbone slave
   input  wire logic                        cyc_i,
   input  wire logic                        stb_i,
   input  wire logic                        we_i,
   input  wire logic [7:0]                  adr_i,
   input  wire logic [3:0]                  sel_i,
   input  wire logic [31:0]                 dat_i,
   output logic      [31:0]                 dat_o,
   output logic                             ack_o,
   // Interrupt
   output logic                             irq_o
);
   import reset_cause_pkg::*;

   logic [1:0]        pins_s;
   logic              external_reset_pin_prev_q;
   logic              bor_prev_q;
   logic              external_reset_pin_fall;
   logic              bor_rise;
   event_e            ev;
   logic              do_reset;
   logic              do_wake;
   logic              do_push;
   logic [PC_W-1:0]   wake_pc;
   logic [RC_W-1:0]   reset_control_reg_q;
   logic [RC_W-1:0]   reset_control_reg_d;
   logic              full_q;
   logic              unf_q;
   logic [SP_W-1:0]   sp_q;
   logic [PC_W-1:0]   tos_q;
   logic              stk_rst_en_q;
   logic [IRQ_W-1:0]  irq_stat_q;
   logic [IRQ_W-1:0]  irq_mask_q;
   logic [IRQ_W-1:0]  irq_set;
   logic [WAKE_W-1:0] wake_flags_q;
   logic              req;
   logic              wr;
   logic              wr_rc;
   logic              wr_sp;
   logic [31:0]       rdata;

   // Pin levels cross into the clock domain before any edge detection
   pin_sync #(
      .WIDTH   (2),
      .RST_VAL (2'h1)
   ) u_pin_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i ({brownout_i, external_reset_pin_n_i}),
      .sync_o  (pins_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         external_reset_pin_prev_q <= 1'b1;
         bor_prev_q  <= 1'b0;
      end else if (ce_i) begin
         external_reset_pin_prev_q <= pins_s[0];
         bor_prev_q  <= pins_s[1];
      end
   end

   assign external_reset_pin_fall = external_reset_pin_prev_q & ~pins_s[0];
   assign bor_rise  = pins_s[1] & ~bor_prev_q & BOR_PRESENT;

   // One event per cycle; a lower-priority event in the same cycle is dropped
   always_comb begin
      ev = EV_NONE;
      if (bor_rise) begin
         ev = EV_BOR;
      end else if (cfg_mismatch_i) begin
         ev = EV_CM;
      end else if (external_reset_pin_fall) begin
         ev = EV_EXTERNAL_RESET_PIN;
      end else if (watchdog_timer_timeout_i) begin
         ev = EV_WDT;
      end else if (stack_overflow_i) begin
         ev = EV_STK_FULL;
      end else if (stack_underflow_i) begin
         ev = EV_STK_UNF;
      end else if (reset_instr_i) begin
         ev = EV_INSTR;
      end else if (int_wake_i && power_mode_i != PM_FULL) begin
         ev = EV_INT_WAKE;
      end
   end

   // Restart kind and restart address
   always_comb begin
      do_reset = 1'b0;
      do_wake  = 1'b0;
      do_push  = 1'b0;
      wake_pc  = pc_i + PC_W'(PC_STEP);
      unique case (ev)
         EV_NONE: begin
         end
         EV_BOR, EV_CM, EV_EXTERNAL_RESET_PIN, EV_INSTR: begin
            do_reset = 1'b1; // [R2] [R3] [R4] [R16]
         end
         EV_WDT: begin
            do_reset = (power_mode_i != PM_IDLE_SLEEP); // [R7]
            do_wake  = (power_mode_i == PM_IDLE_SLEEP); // [R8]
         end
         EV_STK_FULL, EV_STK_UNF: begin
            do_reset = stk_rst_en_q; // [R5] [R6]
         end
         EV_INT_WAKE: begin
            do_wake = 1'b1;
            do_push = high_priority_int_enable_i | low_priority_int_enable_i;
            if (do_push) begin
               wake_pc = int_high_prio_i ? PC_W'(HI_INT_VEC) : PC_W'(LO_INT_VEC); // [R9]
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         restart_o    <= 1'b1;
         core_reset_o <= 1'b1;
         restart_pc_o <= PC_W'(RESTART_VEC); // [R1]
      end else if (ce_i) begin
         restart_o    <= do_reset | do_wake;
         core_reset_o <= do_reset;
         if (do_reset) begin
            restart_pc_o <= PC_W'(RESTART_VEC);
         end else if (do_wake) begin
            restart_pc_o <= wake_pc; // [R8] [R9]
         end
      end
   end

   // Bus decode
   assign req   = cyc_i & stb_i & ~ack_o;
   assign wr    = req & we_i & sel_i[0];
   assign wr_rc = wr & (adr_i == OFF_RESET_CTRL);
   assign wr_sp = wr & (adr_i == OFF_STACK_PTR);

   // Hardware flag changes override a software write in the same cycle
   always_comb begin
      reset_control_reg_d = reset_control_reg_q;
      if (wr_rc) begin
         reset_control_reg_d[BIT_CM]  = dat_i[BIT_CM];
         reset_control_reg_d[BIT_RI]  = dat_i[BIT_RI];
         reset_control_reg_d[BIT_POR] = dat_i[BIT_POR]; // [R15]
         reset_control_reg_d[BIT_BOR] = dat_i[BIT_BOR] & BOR_PRESENT;
      end
      unique case (ev)
         EV_NONE, EV_STK_FULL, EV_STK_UNF: begin
         end
         EV_BOR: begin
            reset_control_reg_d[BIT_CM]  = 1'b1; // [R2]
            reset_control_reg_d[BIT_RI]  = 1'b1;
            reset_control_reg_d[BIT_TO]  = 1'b1;
            reset_control_reg_d[BIT_PD]  = 1'b1;
            reset_control_reg_d[BIT_BOR] = 1'b0;
         end
         EV_CM: begin
            reset_control_reg_d[BIT_CM] = 1'b0; // [R14]
         end
         EV_EXTERNAL_RESET_PIN: begin
            if (power_mode_i != PM_FULL) begin
               reset_control_reg_d[BIT_TO] = 1'b1; // [R3]
            end
            if (power_mode_i == PM_IDLE_SLEEP) begin
               reset_control_reg_d[BIT_PD] = 1'b0; // [R3]
            end
         end
         EV_WDT: begin
            reset_control_reg_d[BIT_TO] = 1'b0; // [R7] [R8]
            if (power_mode_i == PM_IDLE_SLEEP) begin
               reset_control_reg_d[BIT_PD] = 1'b0; // [R8]
            end
         end
         EV_INSTR: begin
            reset_control_reg_d[BIT_RI] = 1'b0; // [R16]
         end
         EV_INT_WAKE: begin
            reset_control_reg_d[BIT_PD] = 1'b0; // [R9]
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_control_reg_q <= RC_POR_VAL; // [R1]
      end else if (ce_i) begin
         reset_control_reg_q <= reset_control_reg_d;
      end
   end

   // Stack flags: hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         full_q <= 1'b0; // [R1]
         unf_q  <= 1'b0;
      end else if (ce_i) begin
         full_q <= (ev == EV_STK_FULL) | (wr_sp ? dat_i[BIT_STK_FULL] : full_q); // [R5]
         unf_q  <= (ev == EV_STK_UNF) | (wr_sp ? dat_i[BIT_STK_UNF] : unf_q); // [R6]
      end
   end

   // Stack pointer and top of stack; a reset empties the stack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_q  <= '0;
         tos_q <= '0;
      end else if (ce_i) begin
         if (do_reset) begin
            sp_q  <= '0;
            tos_q <= '0;
         end else if (do_push) begin
            sp_q  <= sp_q + SP_W'(1); // [R11]
            tos_q <= pc_i; // [R10]
         end else if (wr_sp) begin
            sp_q <= dat_i[SP_W-1:0];
         end
      end
   end

   // Wake-causing interrupt flags survive the wake; only software clears them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_flags_q <= '0;
      end else if (ce_i) begin
         wake_flags_q <= (ev == EV_INT_WAKE ? int_src_flags_i : '0) |
                         (wr & (adr_i == OFF_WAKE_FLAGS) ?
                          wake_flags_q & ~dat_i[WAKE_W-1:0] : wake_flags_q); // [R12]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stk_rst_en_q <= CFG_STK_RST_VAL;
         irq_mask_q   <= '0;
      end else if (ce_i) begin
         if (wr & (adr_i == OFF_CONFIG)) begin
            stk_rst_en_q <= dat_i[BIT_STK_RST_EN];
         end
         if (wr & (adr_i == OFF_INT_MASK)) begin
            irq_mask_q <= dat_i[IRQ_W-1:0];
         end
      end
   end

   // Sticky event bits; set wins over write-one-to-clear
   always_comb begin
      irq_set               = '0;
      irq_set[IRQ_BOR]      = (ev == EV_BOR);
      irq_set[IRQ_CM]       = (ev == EV_CM);
      irq_set[IRQ_EXTERNAL_RESET_PIN]     = (ev == EV_EXTERNAL_RESET_PIN);
      irq_set[IRQ_WDT_RST]  = (ev == EV_WDT) & do_reset;
      irq_set[IRQ_WDT_WAKE] = (ev == EV_WDT) & do_wake;
      irq_set[IRQ_STK_FULL] = (ev == EV_STK_FULL);
      irq_set[IRQ_STK_UNF]  = (ev == EV_STK_UNF);
      irq_set[IRQ_INSTR]    = (ev == EV_INSTR);
      irq_set[IRQ_INT_WAKE] = (ev == EV_INT_WAKE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else if (ce_i) begin
         irq_stat_q <= irq_set | ((wr & (adr_i == OFF_INT_STATUS)) ?
                                  irq_stat_q & ~dat_i[IRQ_W-1:0] : irq_stat_q);
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // Read mux; unmapped offsets and unused bits read zero
   always_comb begin
      rdata = '0;
      unique case (adr_i)
         OFF_RESET_CTRL: rdata[RC_W-1:0] = reset_control_reg_q; // [R13]
         OFF_STACK_PTR: begin
            rdata[BIT_STK_FULL] = full_q;
            rdata[BIT_STK_UNF]  = unf_q;
            rdata[SP_W-1:0]     = sp_q;
         end
         OFF_TOS:        rdata[PC_W-1:0]     = tos_q;
         OFF_CONFIG:     rdata[BIT_STK_RST_EN] = stk_rst_en_q;
         OFF_INT_STATUS: rdata[IRQ_W-1:0]    = irq_stat_q;
         OFF_INT_MASK:   rdata[IRQ_W-1:0]    = irq_mask_q;
         OFF_WAKE_FLAGS: rdata[WAKE_W-1:0]   = wake_flags_q;
         default:        rdata = '0;
      endcase
   end

   // Single wait-free answer: ack one cycle after the request is seen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else if (ce_i) begin
         ack_o <= req;
         if (req) begin
            dat_o <= rdata;
         end
      end
   end

   assign top_of_stack_o   = tos_q;
   assign stack_ptr_o      = sp_q;
   assign held_int_flags_o = wake_flags_q;

   sequence s_int_wake_en;
      ce_i && ev == EV_INT_WAKE && do_push;
   endsequence

   sequence s_vector_out;
      restart_o && !core_reset_o &&
      (restart_pc_o == PC_W'(HI_INT_VEC) || restart_pc_o == PC_W'(LO_INT_VEC));
   endsequence

   bor_flags_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      ce_i && ev == EV_BOR && !wr_rc |=> reset_control_reg_q[5:2] == 4'hF && !reset_control_reg_q[BIT_BOR] &&
      reset_control_reg_q[BIT_POR] == $past(reset_control_reg_q[BIT_POR]) && core_reset_o)
      else $error("brown-out flags wrong");
   external_reset_pin_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      ce_i && ev == EV_EXTERNAL_RESET_PIN && power_mode_i == PM_IDLE_SLEEP
      |=> reset_control_reg_q[BIT_TO] && !reset_control_reg_q[BIT_PD] && restart_pc_o == '0)
      else $error("pin reset in sleep flags wrong");
   external_reset_pin_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      ce_i && ev == EV_EXTERNAL_RESET_PIN && power_mode_i == PM_FULL && !wr_rc
      |=> $stable(reset_control_reg_q) && core_reset_o && restart_pc_o == '0)
      else $error("pin reset at full power changed flags");
   stk_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      ce_i && ev == EV_STK_FULL && stk_rst_en_q |=> full_q && core_reset_o && sp_q == '0)
      else $error("stack full reset wrong");
   stk_unf_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
      ce_i && ev == EV_STK_UNF |=> unf_q && core_reset_o == $past(stk_rst_en_q))
      else $error("underflow handling wrong");
   wdt_reset_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      ce_i && ev == EV_WDT && power_mode_i != PM_IDLE_SLEEP
      |=> !reset_control_reg_q[BIT_TO] && core_reset_o && restart_pc_o == '0)
      else $error("watchdog reset wrong");
   wdt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      ce_i && ev == EV_WDT && power_mode_i == PM_IDLE_SLEEP
      |=> !core_reset_o && restart_o && reset_control_reg_q[3:2] == 2'h0 &&
      restart_pc_o == $past(pc_i) + PC_W'(PC_STEP))
      else $error("watchdog wake wrong");
   int_vector_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
      s_int_wake_en |=> s_vector_out ##0 !reset_control_reg_q[BIT_PD])
      else $error("interrupt wake vector wrong");
   tos_push_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10] [R11]
      s_int_wake_en |=> tos_q == $past(pc_i) && sp_q == $past(sp_q) + SP_W'(1))
      else $error("wake push wrong");
   wake_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
      ce_i && ev == EV_INT_WAKE |=> (wake_flags_q & $past(int_src_flags_i)) ==
      $past(int_src_flags_i))
      else $error("wake flags lost");
   read_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
      ack_o && $past(adr_i) == OFF_RESET_CTRL |-> dat_o[31:RC_W] == '0)
      else $error("unimplemented bits not zero");
   cm_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
      ce_i && ev != EV_CM && ev != EV_BOR && !wr_rc |=> $stable(reset_control_reg_q[BIT_CM]))
      else $error("mismatch flag changed");
   por_sw_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      !wr_rc |=> !$rose(reset_control_reg_q[BIT_POR]))
      else $error("power-on flag set by hardware");
   instr_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
      ce_i && ev == EV_INSTR && !wr_rc |=> !reset_control_reg_q[BIT_RI] &&
      reset_control_reg_q[BIT_TO] == $past(reset_control_reg_q[BIT_TO]) && restart_pc_o == '0)
      else $error("reset instruction flags wrong");

endmodule

// file: testbench/reset_source_model.sv
// Model of the reset sources outside the block: reset pin, supply monitor, watchdog.
// Assumes the bench asks for each source by a one-cycle request on clk_i.
`timescale 1ns/1ps
module reset_source_model #(
   parameter int HOLD = 4
) (
   // Clock
   input  wire logic clk_i,
   // Requests from the bench
   input  wire logic pin_req_i,
   input  wire logic bor_req_i,
   input  wire logic wdt_req_i,
   // Source outputs
   output logic      pin_n_o,
   output logic      brownout_o,
   output logic      wdt_timeout_o
);
   int   pin_cnt = 0;
   int   bor_cnt = 0;
   logic wdt_q   = 1'b0;
   // Pin low longer than the synchroniser window, else the pulse could be lost
   always @(posedge clk_i) begin
      pin_cnt <= pin_req_i ? HOLD : ((pin_cnt > 0) ? pin_cnt - 1 : 0);
      bor_cnt <= bor_req_i ? HOLD : ((bor_cnt > 0) ? bor_cnt - 1 : 0);
      wdt_q   <= wdt_req_i;
   end
   // Pin has a pull-up, so a released pin reads high
   assign pin_n_o       = (pin_cnt == 0);
   assign brownout_o    = (bor_cnt != 0);
   assign wdt_timeout_o = wdt_q;
endmodule

// file: testbench/reset_cause_status_logic_tb_top.sv
// Self-checking bench for the reset-cause block: events, restart point, registers.
// Assumes the source model drives pin, brownout and watchdog; bench drives the rest.
`timescale 1ns/1ps
module reset_cause_status_logic_tb_top;
   import reset_cause_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic [4:0]  ev    = 5'h0;
   logic [2:0]  req   = 3'h0;
   logic        hi_pr = 1'b0, hi_en = 1'b0, lo_en = 1'b0;
   power_mode_e mode  = PM_FULL;
   logic [20:0] pc    = 21'h0;
   logic [7:0]  src   = 8'h0, held, adr = 8'h0;
   logic        pin_n, bor, wdt, rs, cr, irq, ack, seen_rs, seen_cr;
   logic [20:0] rpc, tos;
   logic [4:0]  sp;
   logic        cyc   = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0, rdat, got;
   int          fail_count = 0, tests_run = 0;

   reset_source_model i_reset_source_model (.clk_i(clk_i), .pin_req_i(req[0]),
      .bor_req_i(req[1]), .wdt_req_i(req[2]), .pin_n_o(pin_n), .brownout_o(bor),
      .wdt_timeout_o(wdt));
   reset_cause_status_logic i_reset_cause_status_logic (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .external_reset_pin_n_i(pin_n), .brownout_i(bor), .cfg_mismatch_i(ev[0]),
      .watchdog_timer_timeout_i(wdt), .stack_overflow_i(ev[1]), .stack_underflow_i(ev[2]),
      .reset_instr_i(ev[3]), .int_wake_i(ev[4]), .int_high_prio_i(hi_pr),
      .high_priority_int_enable_i(hi_en), .low_priority_int_enable_i(lo_en),
      .power_mode_i(mode), .pc_i(pc), .int_src_flags_i(src), .restart_o(rs),
      .core_reset_o(cr), .restart_pc_o(rpc), .top_of_stack_o(tos), .stack_ptr_o(sp),
      .held_int_flags_o(held), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Classic cycle; holds everything until ack is seen, then releases for a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (n >= 16) check(32'h0, 32'h1);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(got, e);
   endtask

   // Events 0..4 come from the bench, 5 pin, 6 brownout, 7 watchdog from the model
   task automatic fire(input int k);
      int n;
      n = 0;
      @(posedge clk_i);
      if (k < 5) ev[k] <= 1'b1;
      else req[k-5] <= 1'b1;
      @(posedge clk_i);
      ev      <= 5'h0;
      req     <= 3'h0;
      seen_rs = 1'b0;
      seen_cr = 1'b0;
      while (n < 8) begin
         #1;
         if (rs === 1'b1) begin
            seen_rs = 1'b1;
            seen_cr = cr;
         end
         @(posedge clk_i);
         n++;
      end
   endtask

   task automatic ev_chk(input logic r, input logic c, input logic [20:0] p);
      check({seen_rs, seen_cr, rpc}, {r, c, p});
   endtask

   task automatic t_reset();
      rd(OFF_RESET_CTRL, 32'h3C);
      rd(OFF_STACK_PTR, 32'h0);
      check({11'h0, rpc}, 32'h0);
      rd(OFF_CONFIG, 32'h1);
      rd(OFF_INT_MASK, 32'h0);
   endtask

   task automatic t_por();
      wb(1'b1, OFF_RESET_CTRL, 32'h3F);
      rd(OFF_RESET_CTRL, 32'h3F);
      fire(6);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h3E);
      wb(1'b1, OFF_RESET_CTRL, 32'h3F);
      rd(OFF_RESET_CTRL, 32'h3F);
   endtask

   task automatic t_instr_cm();
      fire(3);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h2F);
      fire(0);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h0F);
   endtask

   task automatic t_wdt_pin();
      mode <= PM_RUN;
      fire(7);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h07);
      fire(5);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h0F);
      mode <= PM_IDLE_SLEEP;
      pc   <= 21'h100;
      fire(7);
      ev_chk(1'b1, 1'b0, 21'h102);
      rd(OFF_RESET_CTRL, 32'h03);
      fire(5);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h0B);
      mode <= PM_FULL;
      fire(5);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h0B);
      fire(7);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_RESET_CTRL, 32'h03);
   endtask

   task automatic t_stack();
      fire(1);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_STACK_PTR, 32'h80);
      rd(OFF_RESET_CTRL, 32'h03);
      wb(1'b1, OFF_CONFIG, 32'h0);
      fire(2);
      ev_chk(1'b0, 1'b0, 21'h0);
      rd(OFF_STACK_PTR, 32'hC0);
      wb(1'b1, OFF_STACK_PTR, 32'h0);
      wb(1'b1, OFF_CONFIG, 32'h1);
      fire(2);
      ev_chk(1'b1, 1'b1, 21'h0);
      rd(OFF_STACK_PTR, 32'h40);
   endtask

   task automatic t_wake();
      fire(6);
      rd(OFF_STACK_PTR, 32'h40);
      rd(OFF_RESET_CTRL, 32'h3E);
      wb(1'b1, OFF_STACK_PTR, 32'h3);
      mode  <= PM_IDLE_SLEEP;
      hi_en <= 1'b1;
      hi_pr <= 1'b1;
      pc    <= 21'h1234;
      src   <= 8'h5A;
      fire(4);
      ev_chk(1'b1, 1'b0, 21'(HI_INT_VEC));
      check({tos, sp}, {21'h1234, 5'h4});
      check({24'h0, held}, 32'h5A);
      rd(OFF_RESET_CTRL, 32'h3A);
      rd(OFF_WAKE_FLAGS, 32'h5A);
      hi_en <= 1'b0;
      lo_en <= 1'b1;
      hi_pr <= 1'b0;
      pc    <= 21'h200;
      fire(4);
      ev_chk(1'b1, 1'b0, 21'(LO_INT_VEC));
      check({tos, sp}, {21'h200, 5'h5});
      lo_en <= 1'b0;
      pc    <= 21'h300;
      fire(4);
      ev_chk(1'b1, 1'b0, 21'h302);
      check({tos, sp}, {21'h200, 5'h5});
      // Enable low: an event in that window must leave no trace
      ce_i <= 1'b0;
      fire(3);
      ce_i <= 1'b1;
      ev_chk(1'b0, 1'b0, 21'h302);
      rd(OFF_RESET_CTRL, 32'h3A);
   endtask

   // Every event class has fired by now, so all status bits are expected set
   task automatic t_irq_regs();
      rd(OFF_INT_STATUS, 32'h1FF);
      check({31'h0, irq}, 32'h0);
      wb(1'b1, OFF_INT_MASK, 32'h100);
      check({31'h0, irq}, 32'h1);
      wb(1'b1, OFF_INT_STATUS, 32'h100);
      check({31'h0, irq}, 32'h0);
      rd(OFF_INT_STATUS, 32'hFF);
      wb(1'b1, 8'h1C, 32'hFFFFFFFF);
      rd(8'h1C, 32'h0);
      wb(1'b1, OFF_TOS, 32'h0);
      rd(OFF_TOS, 32'h200);
      wb(1'b1, OFF_WAKE_FLAGS, 32'h5A);
      rd(OFF_WAKE_FLAGS, 32'h0);
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_por();
      t_instr_cm();
      t_wdt_pin();
      t_stack();
      t_wake();
      t_irq_regs();
      final_report();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      final_report();
   end
endmodule
